// file: verilog/btt_pkg.sv
// Constants and carrier types of the bus trace capture unit
`default_nettype none
package btt_pkg;
  localparam int AW   = 24;   // Target address width
  localparam int DW   = 16;   // Target data width
  localparam int XW   = 8;    // External probe lines
  localparam int NTRIG = 3;
  localparam int NSET = 4;    // Three triggers plus the filter
  localparam int FSET = 3;    // Index of the filter set
  localparam int CW   = 16;   // Counter width
  localparam int NPER = 4;    // Peripherals told about freeze
  localparam int CMDW = 16;   // Debug serial word
  localparam int OW   = 8;    // Decoded offset bits
  localparam int CLK_NS = 10;
  localparam int BIT_NS = 250;  // 4 Mbit/s ceiling
  localparam int HALF = (BIT_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam logic [CW-1:0] DEPTH    = 16'h0800;
  localparam logic [CW-1:0] POST_RST = DEPTH >> 1;
  localparam logic [CW-1:0] REP_RST  = 16'h0001;
  localparam logic [OW-1:0] R_CTRL = 8'h00;
  localparam logic [OW-1:0] R_EFF  = 8'h04;
  localparam logic [OW-1:0] R_REP  = 8'h08;
  localparam logic [OW-1:0] R_POST = 8'h0C;
  localparam logic [OW-1:0] R_STAT = 8'h10;
  localparam logic [OW-1:0] R_DCTL = 8'h14;
  localparam logic [OW-1:0] R_DCMD = 8'h18;
  localparam logic [OW-1:0] R_DRX  = 8'h1C;
  localparam int SET_BIT = 7;  // Sets at 0x80 + 0x20 * set
  localparam int SET_HI = 6;
  localparam int SET_LO = 5;
  localparam int FLD_HI = 4;
  localparam int FLD_LO = 2;
  localparam logic [2:0] F_CFG = 3'h0;
  localparam logic [2:0] F_ALO = 3'h1;
  localparam logic [2:0] F_AHI = 3'h2;
  localparam logic [2:0] F_DLO = 3'h3;
  localparam logic [2:0] F_DHI = 3'h4;
  typedef enum logic [1:0] {CT_ALL = 2'h0, CT_FETCH = 2'h1, CT_DATA = 2'h2, CT_NONE = 2'h3} btt_ctype_t;
  typedef enum logic [1:0] {DT_ALL = 2'h0, DT_READ = 2'h1, DT_WRITE = 2'h2, DT_NONE = 2'h3} btt_dtype_t;
  typedef enum logic [1:0] {EF_NONE = 2'h0, EF_STOP = 2'h1, EF_START = 2'h2, EF_COUNT = 2'h3} btt_eff_t;
  typedef enum logic [2:0] {S_IDLE = 3'h1, S_LOW = 3'h2, S_HIGH = 3'h4} btt_ser_t;
  typedef struct packed {
    logic [AW-1:0] addr; logic [DW-1:0] data; logic [XW-1:0] ext;
    logic opcode_fetch_cycle; logic rd; logic wr;
  } btt_frame_t;
  typedef struct packed { logic pat; btt_dtype_t dtype; btt_ctype_t ctype; } btt_cfg_t;
  typedef struct packed {
    btt_cfg_t cfg; logic [AW-1:0] alo; logic [AW-1:0] ahi; logic [DW-1:0] dlo; logic [DW-1:0] dhi;
  } btt_qual_t;
  typedef struct packed {
    logic [1:0] fsel; logic brks; logic brkt; logic win; logic once; logic xinh; logic fen;
    logic [NTRIG-1:0] ten;
  } btt_ctrl_t;
  typedef struct packed {
    logic [CW-1:0] post_left; logic [1:0] stage; logic counting; logic halt;
    logic done; logic rec_on; logic triggered;
  } btt_stat_t;
  typedef struct packed { logic busy; logic bkgd; logic resume; logic [NPER-1:0] resp; } btt_dctl_t;
endpackage : btt_pkg
`default_nettype wire

// file: verilog/btt_capture.sv
// Trigger, filter and capture logic with its AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - While armed inhibit pin is low, triggers are ignored; release keeps them enabled.
// - Normal pulse mode pulses trigger output on every qualified trigger.
// - Pulse-once mode pulses trigger output only on the first trigger.
// - Count hits of highest active trigger; trigger when count reaches repeat value.
// - After the trigger, store exactly the post count of frames, then stop.
// - Normal filter mode: each trigger stops, starts, or starts the ending countdown.
// - Window filter mode: filter set decides per bus cycle whether it is stored.
// - Cycle type: all, opcode fetches only, data cycles only, or none.
// - Address matches between programmable start and end addresses.
// - Data matches a low-to-high range, or one exact pattern value.
// - Data type: all cycles, reads only, writes only, or none.
// - Three trigger sets, each enabled separately by software.
// - Filter enabled: recording waits until the selected trigger pass completes.
// - Optional halt request on trigger and, separately, on trace stop.
// - Default post count puts the trigger at the buffer's halfway mark.
// - Debug commands travel on a synchronous serial line at 4 Mbit/s at most.
// - Entering background debug state raises the freeze output.
// - Each peripheral may be set to halt on freeze or ignore it.
// - After reset every frame is stored and no trigger occurs.
// - Eight external probe lines are stored with each recorded cycle.
module btt_capture #(
  parameter int HALF_CYC = btt_pkg::HALF
) (
  input  wire  logic                      CLK,
  input  wire  logic                      ARST_N,
  input  wire  logic                      HSEL,
  input  wire  logic [31:0]               HADDR,
  input  wire  logic [1:0]                HTRANS,
  input  wire  logic                      HWRITE,
  input  wire  logic [2:0]                HSIZE,
  input  wire  logic [31:0]               HWDATA,
  input  wire  logic                      HREADY,
  output var   logic                      HREADYOUT,
  output var   logic                      HRESP,
  output var   logic [31:0]               HRDATA,
  input  wire  btt_pkg::btt_frame_t       TGT_FRAME,
  input  wire  logic                      TGT_STROBE,
  input  wire  logic                      TRIG_INH_N,
  input  wire  logic                      BKGD_REQ,
  input  wire  logic                      DBG_DSO,
  output var   logic                      REC_VALID,
  output var   btt_pkg::btt_frame_t       REC_FRAME,
  output var   logic                      TRIG_OUT,
  output var   logic                      HALT_REQ,
  output var   logic                      FREEZE,
  output var   logic [btt_pkg::NPER-1:0]  PERIPH_HALT,
  output var   logic                      DBG_DSCLK,
  output var   logic                      DBG_DSI
);
  localparam int FW = $bits(btt_pkg::btt_frame_t);
  localparam int SW = FW + 4;

  logic [SW-1:0]             s1;
  logic [SW-1:0]             s2;
  btt_pkg::btt_frame_t       fr;
  logic                      stb_s;
  logic                      inh_s;
  logic                      bkq_s;
  logic                      dso_s;
  logic                      stb_d;
  logic                      fe;
  logic                      acc;
  logic                      wr_pend;
  logic [btt_pkg::OW-1:0]    wr_ofs;
  logic [btt_pkg::OW-1:0]    rofs;
  logic [31:0]               rd_mux;
  btt_pkg::btt_ctrl_t        ctrl;
  logic [btt_pkg::NTRIG-1:0][1:0] eff;
  logic [btt_pkg::CW-1:0]    rep;
  logic [btt_pkg::CW-1:0]    post;
  logic [btt_pkg::NPER-1:0]  dresp;
  btt_pkg::btt_qual_t        qual [btt_pkg::NSET];
  btt_pkg::btt_dctl_t        dw;
  logic                      ctrl_wr;
  logic                      arm;
  logic [btt_pkg::NSET-1:0]  hit;
  logic [1:0]                stage;
  logic [1:0]                first_idx;
  logic [1:0]                hi_idx;
  logic [1:0]                nxt_idx;
  logic [btt_pkg::CW-1:0]    rep_cnt;
  logic                      triggered;
  logic                      released;
  logic                      gate;
  logic                      cur_hit;
  logic                      last_hit;
  logic                      fire;
  logic                      store;
  btt_pkg::btt_eff_t         eff_s;
  logic                      apply_eff;
  logic                      start_cd;
  logic                      done_set;
  logic                      stop_ev;
  logic                      rec_on;
  logic                      done;
  logic                      counting;
  logic [btt_pkg::CW-1:0]    post_left;
  logic                      bkgd;
  btt_pkg::btt_ser_t         ser;
  logic [7:0]                hc;
  logic [4:0]                bits;
  logic [btt_pkg::CMDW-1:0]  sh;

  // Every target-side input crosses on two flops before use
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1 <= '0;
      s2 <= '0;
      stb_d <= 1'b0;
    end else begin
      s1 <= {TGT_FRAME, TGT_STROBE, TRIG_INH_N, BKGD_REQ, DBG_DSO};
      s2 <= s1;
      stb_d <= stb_s;
    end
  end
  assign {fr, stb_s, inh_s, bkq_s, dso_s} = s2;
  // Frame fields must be steady around the strobe edge; they are not re-registered
  assign fe = stb_s & ~stb_d;

  // AHB-Lite slave: zero wait states, always OKAY
  assign acc = HSEL & HTRANS[1] & HREADY;
  assign rofs = HADDR[btt_pkg::OW-1:0];
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_pend <= 1'b0;
      wr_ofs <= '0;
      HRDATA <= '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend <= acc & HWRITE;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (acc) begin
        wr_ofs <= rofs;
      end
      if (acc && !HWRITE) begin
        HRDATA <= rd_mux;
      end
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    if (rofs[btt_pkg::SET_BIT]) begin
      case (rofs[btt_pkg::FLD_HI:btt_pkg::FLD_LO])
        btt_pkg::F_CFG: rd_mux = 32'(qual[rofs[btt_pkg::SET_HI:btt_pkg::SET_LO]].cfg);
        btt_pkg::F_ALO: rd_mux = 32'(qual[rofs[btt_pkg::SET_HI:btt_pkg::SET_LO]].alo);
        btt_pkg::F_AHI: rd_mux = 32'(qual[rofs[btt_pkg::SET_HI:btt_pkg::SET_LO]].ahi);
        btt_pkg::F_DLO: rd_mux = 32'(qual[rofs[btt_pkg::SET_HI:btt_pkg::SET_LO]].dlo);
        btt_pkg::F_DHI: rd_mux = 32'(qual[rofs[btt_pkg::SET_HI:btt_pkg::SET_LO]].dhi);
        default: rd_mux = '0;
      endcase
    end else begin
      case (rofs)
        btt_pkg::R_CTRL: rd_mux = 32'(ctrl);
        btt_pkg::R_EFF: rd_mux = 32'(eff);
        btt_pkg::R_REP: rd_mux = 32'(rep);
        btt_pkg::R_POST: rd_mux = 32'(post);
        btt_pkg::R_STAT: rd_mux = 32'(btt_pkg::btt_stat_t'({post_left, stage, counting, HALT_REQ,
                                                         done, rec_on, triggered}));
        btt_pkg::R_DCTL: rd_mux = 32'(btt_pkg::btt_dctl_t'({ser != btt_pkg::S_IDLE, bkgd, 1'b0, dresp}));
        btt_pkg::R_DRX: rd_mux = 32'(sh);
        default: rd_mux = '0;
      endcase
    end
  end

  // Configuration writes; a control write re-arms the sequencer a cycle later
  assign ctrl_wr = wr_pend && (wr_ofs == btt_pkg::R_CTRL);
  assign dw = btt_pkg::btt_dctl_t'(HWDATA[$bits(btt_pkg::btt_dctl_t)-1:0]);
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl <= '0;
      eff <= '0;
      rep <= btt_pkg::REP_RST;
      post <= btt_pkg::POST_RST;
      dresp <= '0;
      arm <= 1'b0;
      for (int i = 0; i < btt_pkg::NSET; i++) begin
        qual[i] <= '0;
      end
    end else begin
      arm <= ctrl_wr;
      if (wr_pend && !wr_ofs[btt_pkg::SET_BIT]) begin
        case (wr_ofs)
          btt_pkg::R_CTRL: ctrl <= btt_pkg::btt_ctrl_t'(HWDATA[$bits(btt_pkg::btt_ctrl_t)-1:0]);
          btt_pkg::R_EFF: eff <= HWDATA[2*btt_pkg::NTRIG-1:0];
          btt_pkg::R_REP: rep <= HWDATA[btt_pkg::CW-1:0];
          btt_pkg::R_POST: post <= HWDATA[btt_pkg::CW-1:0];
          btt_pkg::R_DCTL: dresp <= dw.resp;
          default: ;
        endcase
      end
      if (wr_pend && wr_ofs[btt_pkg::SET_BIT]) begin
        case (wr_ofs[btt_pkg::FLD_HI:btt_pkg::FLD_LO])
          btt_pkg::F_CFG: qual[wr_ofs[btt_pkg::SET_HI:btt_pkg::SET_LO]].cfg <=
            btt_pkg::btt_cfg_t'(HWDATA[$bits(btt_pkg::btt_cfg_t)-1:0]);
          btt_pkg::F_ALO: qual[wr_ofs[btt_pkg::SET_HI:btt_pkg::SET_LO]].alo <= HWDATA[btt_pkg::AW-1:0];
          btt_pkg::F_AHI: qual[wr_ofs[btt_pkg::SET_HI:btt_pkg::SET_LO]].ahi <= HWDATA[btt_pkg::AW-1:0];
          btt_pkg::F_DLO: qual[wr_ofs[btt_pkg::SET_HI:btt_pkg::SET_LO]].dlo <= HWDATA[btt_pkg::DW-1:0];
          btt_pkg::F_DHI: qual[wr_ofs[btt_pkg::SET_HI:btt_pkg::SET_LO]].dhi <= HWDATA[btt_pkg::DW-1:0];
          default: ;
        endcase
      end
    end
  end

  // One comparator set per trigger and for the filter
  for (genvar g = 0; g < btt_pkg::NSET; g++) begin : g_qual
    logic ct_ok;
    logic dt_ok;
    logic a_ok;
    logic d_ok;
    always_comb begin
      unique case (qual[g].cfg.ctype)
        btt_pkg::CT_ALL: ct_ok = 1'b1;
        btt_pkg::CT_FETCH: ct_ok = fr.opcode_fetch_cycle;
        btt_pkg::CT_DATA: ct_ok = !fr.opcode_fetch_cycle && (fr.rd || fr.wr);
        btt_pkg::CT_NONE: ct_ok = 1'b0;
      endcase
      unique case (qual[g].cfg.dtype)
        btt_pkg::DT_ALL: dt_ok = 1'b1;
        btt_pkg::DT_READ: dt_ok = fr.rd;
        btt_pkg::DT_WRITE: dt_ok = fr.wr;
        btt_pkg::DT_NONE: dt_ok = 1'b0;
      endcase
    end
    assign a_ok = (fr.addr >= qual[g].alo) && (fr.addr <= qual[g].ahi);
    assign d_ok = qual[g].cfg.pat ? (fr.data == qual[g].dlo)
                                  : ((fr.data >= qual[g].dlo) && (fr.data <= qual[g].dhi));
    assign hit[g] = ct_ok & a_ok & dt_ok & d_ok;
  end

  // Lowest, highest and next active trigger
  always_comb begin
    first_idx = '0;
    hi_idx = '0;
    nxt_idx = stage;
    for (int i = btt_pkg::NTRIG - 1; i >= 0; i--) begin
      if (ctrl.ten[i]) begin
        first_idx = 2'(i);
      end
      if (ctrl.ten[i] && (2'(i) > stage)) begin
        nxt_idx = 2'(i);
      end
    end
    for (int i = 0; i < btt_pkg::NTRIG; i++) begin
      if (ctrl.ten[i]) begin
        hi_idx = 2'(i);
      end
    end
  end

  // Trigger evaluation terms
  assign gate = !ctrl.xinh || released || inh_s;
  assign cur_hit = fe && gate && ctrl.ten[stage] && hit[stage];
  assign last_hit = cur_hit && (stage == hi_idx);
  assign fire = last_hit && !triggered && (({1'b0, rep_cnt} + 1'b1) >= {1'b0, rep});
  assign store = fe && rec_on && !done && (!ctrl.win || hit[btt_pkg::FSET]);
  assign eff_s = btt_pkg::btt_eff_t'(eff[stage]);
  assign apply_eff = cur_hit && !ctrl.win;
  assign start_cd = !counting && (fire || (apply_eff && (eff_s == btt_pkg::EF_COUNT)));
  assign done_set = (start_cd && (post == '0)) || (counting && store && (post_left == 1));
  assign stop_ev = done_set || (apply_eff && (eff_s == btt_pkg::EF_STOP));

  // Trigger sequencer
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stage <= '0;
      rep_cnt <= '0;
      triggered <= 1'b0;
      released <= 1'b0;
    end else if (arm) begin
      stage <= first_idx;
      rep_cnt <= '0;
      triggered <= 1'b0;
      released <= 1'b0;
    end else begin
      if (inh_s) begin
        released <= 1'b1;
      end
      if (cur_hit && (stage != hi_idx)) begin
        stage <= nxt_idx;
      end
      if (last_hit && !triggered) begin
        rep_cnt <= rep_cnt + 1'b1;
      end
      if (fire) begin
        triggered <= 1'b1;
      end
    end
  end

  // Recording window and post-trigger countdown
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rec_on <= 1'b1;
      done <= 1'b0;
      counting <= 1'b0;
      post_left <= '0;
    end else if (arm) begin
      rec_on <= !ctrl.fen;
      done <= 1'b0;
      counting <= 1'b0;
      post_left <= '0;
    end else begin
      if (ctrl.fen && cur_hit && (stage == ctrl.fsel)) begin
        rec_on <= 1'b1;
      end
      if (apply_eff && (eff_s == btt_pkg::EF_STOP)) begin
        rec_on <= 1'b0;
      end
      if (apply_eff && (eff_s == btt_pkg::EF_START)) begin
        rec_on <= 1'b1;
      end
      if (done_set) begin
        done <= 1'b1;
      end
      // Trigger frame is not counted, whether or not it is stored
      if (start_cd) begin
        counting <= (post != '0);
        post_left <= post;
      end else if (counting && store) begin
        post_left <= post_left - 1'b1;
        counting <= (post_left != 1);
      end
    end
  end

  // Registered outputs toward the trace memory and the emulator
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REC_VALID <= 1'b0;
      REC_FRAME <= '0;
      TRIG_OUT <= 1'b0;
      HALT_REQ <= 1'b0;
    end else begin
      REC_VALID <= store;
      if (store) begin
        REC_FRAME <= fr;
      end
      TRIG_OUT <= last_hit && (fire || (triggered && !ctrl.once));
      // Set wins over the re-arm clear so a coincident stop is not lost
      if ((fire && ctrl.brkt) || (stop_ev && ctrl.brks)) begin
        HALT_REQ <= 1'b1;
      end else if (arm) begin
        HALT_REQ <= 1'b0;
      end
    end
  end

  // Background debug state; a pending request wins over resume
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bkgd <= 1'b0;
      FREEZE <= 1'b0;
      PERIPH_HALT <= '0;
    end else begin
      if (bkq_s) begin
        bkgd <= 1'b1;
      end else if (wr_pend && (wr_ofs == btt_pkg::R_DCTL) && dw.resume) begin
        bkgd <= 1'b0;
      end
      FREEZE <= bkgd;
      PERIPH_HALT <= {btt_pkg::NPER{bkgd}} & dresp;
    end
  end

  // Debug serial shifter; half period rounded up keeps the rate at or under the ceiling
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ser <= btt_pkg::S_IDLE;
      hc <= '0;
      bits <= '0;
      sh <= '0;
      DBG_DSCLK <= 1'b0;
      DBG_DSI <= 1'b0;
    end else begin
      unique case (ser)
        btt_pkg::S_IDLE: begin
          if (wr_pend && (wr_ofs == btt_pkg::R_DCMD) && bkgd) begin
            sh <= HWDATA[btt_pkg::CMDW-1:0];
            DBG_DSI <= HWDATA[btt_pkg::CMDW-1];
            bits <= 5'(btt_pkg::CMDW);
            hc <= '0;
            ser <= btt_pkg::S_LOW;
          end
        end
        btt_pkg::S_LOW: begin
          if (hc == 8'(HALF_CYC - 1)) begin
            hc <= '0;
            DBG_DSCLK <= 1'b1;
            sh <= {sh[btt_pkg::CMDW-2:0], dso_s};
            ser <= btt_pkg::S_HIGH;
          end else begin
            hc <= hc + 1'b1;
          end
        end
        btt_pkg::S_HIGH: begin
          if (hc == 8'(HALF_CYC - 1)) begin
            hc <= '0;
            DBG_DSCLK <= 1'b0;
            bits <= bits - 1'b1;
            DBG_DSI <= sh[btt_pkg::CMDW-1];
            ser <= (bits == 5'h01) ? btt_pkg::S_IDLE : btt_pkg::S_LOW;
          end else begin
            hc <= hc + 1'b1;
          end
        end
      endcase
    end
  end

  // Helper: cycles since the serial clock last moved
  logic [7:0] clk_run;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clk_run <= '0;
    end else if (ser == btt_pkg::S_IDLE) begin
      clk_run <= 8'hFF;
    end else if (DBG_DSCLK != $past(DBG_DSCLK)) begin
      clk_run <= '0;
    end else if (clk_run != 8'hFF) begin
      clk_run <= clk_run + 1'b1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_inhibit_quiet:
    assert property (fe && ctrl.xinh && !released && !inh_s && !arm |=> !TRIG_OUT && !$rose(triggered))
    else $error("trigger while inhibit held");
  a_pulse_each:
    assert property (last_hit && triggered && !ctrl.once && !arm |=> TRIG_OUT)
    else $error("missing repeat trigger pulse");
  a_pulse_single:
    assert property (triggered && ctrl.once |=> !TRIG_OUT)
    else $error("second pulse in pulse-once mode");
  a_repeat_reached:
    assert property ($rose(triggered) |-> ({1'b0, $past(rep_cnt)} + 1'b1) >= {1'b0, rep})
    else $error("trigger before repeat count");
  a_no_store_done:
    assert property (done |=> !REC_VALID)
    else $error("frame stored after stop");
  a_post_decrement:
    assert property (counting && store && !start_cd && !arm |=> post_left == $past(post_left) - 1'b1)
    else $error("post count not decremented");
  a_effect_stop:
    assert property (apply_eff && eff_s == btt_pkg::EF_STOP && !arm |=> !rec_on ##1 !REC_VALID)
    else $error("stop effect ignored");
  a_window_skip:
    assert property (fe && ctrl.win && !hit[btt_pkg::FSET] |=> !REC_VALID)
    else $error("window mode stored unmatched cycle");
  a_filter_hold:
    assert property (ctrl.fen && !rec_on |=> !REC_VALID)
    else $error("capture before filter pass");
  a_halt_trig:
    assert property (fire && ctrl.brkt && !arm |=> HALT_REQ)
    else $error("no halt on trigger");
  a_freeze_follow:
    assert property (bkq_s |=> ##1 FREEZE)
    else $error("freeze not raised");
  a_serial_rate:
    assert property ($changed(DBG_DSCLK) && ser != btt_pkg::S_IDLE |-> $past(clk_run) >= 8'(HALF_CYC - 2))
    else $error("serial clock too fast");

  c_trigger_fired: cover property (fire ##[1:50] done);
  c_window_store: cover property (ctrl.win && store);
  c_serial_word: cover property (ser == btt_pkg::S_HIGH ##1 ser == btt_pkg::S_IDLE);
  c_repeat_two: cover property (last_hit && !fire ##[1:100] fire);
endmodule : btt_capture
`default_nettype wire

// file: verif/btt_target_model.sv
// Target bus model issuing traced bus cycles
`timescale 1ns/1ps
`default_nettype none
module btt_target_model (
  input  wire logic                CLK,
  output var  btt_pkg::btt_frame_t FRAME,
  output var  logic                STROBE
);
  initial begin
    FRAME = '0;
    STROBE = 1'b0;
  end
  // Fields settle two edges early, hold past capture
  task automatic send(input btt_pkg::btt_frame_t f);
    FRAME <= f;
    repeat (2) @(posedge CLK);
    STROBE <= 1'b1;
    repeat (3) @(posedge CLK);
    STROBE <= 1'b0;
    repeat (2) @(posedge CLK);
    FRAME <= ~f; // Released bus, never the old frame
    @(posedge CLK);
  endtask : send
endmodule : btt_target_model
`default_nettype wire

// file: verif/bus_trace_trigger_capture_tb_top.sv
// Self-checking bench of the trace capture unit
`timescale 1ns/1ps
`default_nettype none
module bus_trace_trigger_capture_tb_top;
  logic                clk = 0, arst_n = 0, hsel = 0, hwrite = 0, inh_n = 0;
  logic                rdy, tout, rv, ts, halt, frz, dsclk, dsi, bkq = 0;
  logic [3:0]          ph;
  logic [1:0]          htrans = 0;
  logic [31:0]         haddr = 0, hwdata = 0, hrdata, rdv;
  btt_pkg::btt_frame_t tf, rf;
  btt_pkg::btt_frame_t got[$];
  int                  failures = 0, tests_run = 0, ntrig, nclk = 0;

  // Default half period: the controller echo below needs the full serial bit time
  btt_capture #(.HALF_CYC(btt_pkg::HALF)) u_dut (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy),
    .HREADYOUT(rdy), .HRESP(), .HRDATA(hrdata), .TGT_FRAME(tf), .TGT_STROBE(ts),
    .TRIG_INH_N(inh_n), .BKGD_REQ(bkq), .DBG_DSO(dsi), .REC_VALID(rv), .REC_FRAME(rf),
    .TRIG_OUT(tout), .HALT_REQ(halt), .FREEZE(frz), .PERIPH_HALT(ph), .DBG_DSCLK(dsclk), .DBG_DSI(dsi));
  btt_target_model u_tgt (.CLK(clk), .FRAME(tf), .STROBE(ts));

  always #5 clk = ~clk;
  // Far side counts serial clock rises
  always @(posedge dsclk) nclk++;
  // Outputs sampled mid-cycle, away from update edge
  always @(negedge clk) begin
    if (rv === 1'b1) got.push_back(rf);
    if (tout === 1'b1) ntrig++;
  end

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen %0h exp %0h", $time, s, e);
    end
  endtask : chk

  // One single AHB-Lite word transfer
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rdv = hrdata;
  endtask : bus

  function automatic btt_pkg::btt_frame_t mk(input logic [23:0] a, input logic [15:0] d);
    logic [63:0] r;
    r = {$urandom, $urandom};
    mk = r[50:0];
    mk.addr = a;
    mk.data = d;
    mk.opcode_fetch_cycle = 1'b1;
    mk.rd = 1'b1;
    mk.wr = 1'b0;
  endfunction : mk

  // One bus cycle against the expected store and pulse counts
  task automatic fr(input btt_pkg::btt_frame_t x, input int er, input int et);
    got.delete();
    ntrig = 0;
    u_tgt.send(x);
    chk(got.size(), er);
    chk(ntrig, et);
    if (er == 1 && got.size() == 1) chk(got[0], x);
  endtask : fr

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    failures++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hD7B6F447));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, btt_pkg::R_POST, 0);
    chk(rdv, 32'(btt_pkg::DEPTH >> 1));
    bus(1'b0, btt_pkg::R_REP, 0);
    chk(rdv, 32'h1);
    bus(1'b0, 32'h20, 0);
    chk(rdv, 32'h0);
    repeat (3) fr(mk(24'($urandom), 16'($urandom)), 1, 0);
    // Set 0: address 100..1FF, data 10..20, two hits needed
    bus(1'b1, 32'h80, 0);
    bus(1'b1, 32'h84, 32'h100);
    bus(1'b1, 32'h88, 32'h1FF);
    bus(1'b1, 32'h8C, 32'h10);
    bus(1'b1, 32'h90, 32'h20);
    bus(1'b1, btt_pkg::R_EFF, 0);
    bus(1'b1, btt_pkg::R_REP, 2);
    bus(1'b1, btt_pkg::R_POST, 1);
    bus(1'b1, btt_pkg::R_CTRL, 1);
    fr(mk(24'h050, 16'h15), 1, 0);
    fr(mk(24'h100, 16'h10), 1, 0);
    fr(mk(24'h1FF, 16'h20), 1, 1);
    fr(mk(24'h000, 16'h00), 1, 0);
    fr(mk(24'h180, 16'h18), 0, 1);
    fr(mk(24'h180, 16'h21), 0, 0);
    // Pulse once after re-arm
    bus(1'b1, btt_pkg::R_REP, 1);
    bus(1'b1, btt_pkg::R_CTRL, 32'h21);
    fr(mk(24'h180, 16'h18), 1, 1);
    fr(mk(24'h180, 16'h18), 1, 0);
    fr(mk(24'h180, 16'h18), 0, 0);
    // Every cycle type and data type code on a read fetch
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 32'h80, (i < 4) ? i : (i % 4) << 2);
      bus(1'b1, btt_pkg::R_CTRL, 1);
      fr(mk(24'h180, 16'h18), 1, int'(i % 4 < 2));
    end
    // Pattern compares the low value only
    bus(1'b1, 32'h80, 32'h10);
    bus(1'b1, btt_pkg::R_CTRL, 1);
    fr(mk(24'h180, 16'h18), 1, 0);
    fr(mk(24'h180, 16'h10), 1, 1);
    // Inhibit pin holds off, release latches enable
    bus(1'b1, btt_pkg::R_CTRL, 32'h11);
    fr(mk(24'h180, 16'h10), 1, 0);
    inh_n <= 1'b1;
    fr(mk(24'h180, 16'h10), 1, 1);
    inh_n <= 1'b0;
    fr(mk(24'h180, 16'h10), 1, 1);
    // Window mode: the filter set alone decides storage
    bus(1'b1, 32'hE8, 32'hFF);
    bus(1'b1, 32'hF0, 32'hFFFF);
    bus(1'b1, btt_pkg::R_CTRL, 32'h41);
    fr(mk(24'h080, 16'h10), 1, 0);
    fr(mk(24'h180, 16'h10), 0, 1);
    // Filter holds capture until trigger 0 passes; halt on trigger
    bus(1'b1, btt_pkg::R_CTRL, 32'h89);
    fr(mk(24'h050, 16'h10), 0, 0);
    chk(halt, 1'b0);
    fr(mk(24'h180, 16'h10), 0, 1);
    chk(halt, 1'b1);
    fr(mk(24'h050, 16'h10), 1, 0);
    // Stop effect ends recording and requests a halt on trace stop
    bus(1'b1, btt_pkg::R_EFF, 1);
    bus(1'b1, btt_pkg::R_CTRL, 32'h101);
    fr(mk(24'h180, 16'h10), 1, 1);
    chk(halt, 1'b1);
    fr(mk(24'h050, 16'h10), 0, 0);
    // Background state: freeze, peripheral halts, echoed serial word
    bus(1'b1, btt_pkg::R_DCTL, 32'h5);
    bkq <= 1'b1;
    repeat (5) @(posedge clk);
    chk(frz, 1'b1);
    chk(ph, 4'h5);
    bus(1'b1, btt_pkg::R_DCMD, 32'hA5C3);
    repeat (450) @(posedge clk);
    bus(1'b0, btt_pkg::R_DRX, 0);
    chk(rdv, 32'hA5C3);
    chk(nclk, btt_pkg::CMDW);
    bus(1'b0, btt_pkg::R_DCTL, 0);
    chk(rdv, 32'h25);
    bkq <= 1'b0;
    repeat (3) @(posedge clk);
    bus(1'b1, btt_pkg::R_DCTL, 32'h15);
    repeat (2) @(posedge clk);
    chk(frz, 1'b0);
    chk(ph, 4'h0);
    wrap_up();
  end
endmodule : bus_trace_trigger_capture_tb_top
`default_nettype wire
